// ===== common/sysctl_pkg.sv
// constants, register map and state codes of the system control block
package sysctl_pkg;
	// clocks
	localparam int unsigned CLK_FREQ_HZ = 100_000_000;
	localparam int unsigned SYS_FREQ_HZ = 1_000_000;
	localparam int unsigned SYS_DIV = CLK_FREQ_HZ / SYS_FREQ_HZ;
	// timing, each figure in its own unit, then in clock cycles
	localparam int unsigned INIT_TIME_MS = 16;
	localparam int unsigned INIT_CYCLES = INIT_TIME_MS * (CLK_FREQ_HZ / 1000);
	localparam int unsigned WDOG_TIME_MS = 450;
	localparam int unsigned WDOG_CYCLES = WDOG_TIME_MS * (CLK_FREQ_HZ / 1000);
	localparam int unsigned WAKE_TIME_US = 60;
	localparam int unsigned WAKE_CYCLES = WAKE_TIME_US * (CLK_FREQ_HZ / 1_000_000);
	localparam int unsigned SCAN_FAST_HZ = 125;
	localparam int unsigned SCAN_CYCLES = CLK_FREQ_HZ / SCAN_FAST_HZ;
	localparam int unsigned SCAN_PULSE_US = 1;
	localparam int unsigned SCAN_PULSE_CYCLES = SCAN_PULSE_US * (CLK_FREQ_HZ / 1_000_000);
	// widths
	localparam int unsigned NUM_PINS = 13;
	localparam int unsigned AW = 4;
	localparam int unsigned DW = 16;
	// register offsets
	localparam logic [3:0] ADDR_DIR_A = 4'h0;
	localparam logic [3:0] ADDR_DIR_D = 4'h3;
	localparam logic [3:0] ADDR_PINS = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h5;
	localparam logic [3:0] ADDR_CMD = 4'h6;
	localparam logic [3:0] ADDR_SCAN_EN = 4'h7;
	localparam logic [3:0] ADDR_CONFIG = 4'h8;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h9;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'ha;
	// command codes
	localparam logic [15:0] CMD_CLEAR_FIRST = 16'h0001;
	localparam logic [15:0] CMD_CLEAR_SECOND = 16'h0002;
	localparam logic [15:0] CMD_HALT = 16'h0003;
	// field positions
	localparam int unsigned STAT_LOW_BAT = 0;
	localparam int unsigned STAT_CAUSE_LSB = 1;
	localparam int unsigned CFG_WAKE_PA3 = 0;
	localparam int unsigned CFG_WAKE_PD0 = 1;
	localparam int unsigned CFG_RATE_LSB = 2;
	localparam int unsigned IRQ_WAKE = 0;
	localparam int unsigned IRQ_LOW_BAT = 1;
	localparam int unsigned PIN_PA3 = 3;
	localparam int unsigned PIN_PD0 = 12;
	// reset values
	localparam logic [12:0] DIR_RESET = 13'h1fff;
	localparam logic [3:0] CFG_RESET = 4'h3;
	localparam logic [2:0] CAUSE_POR = 3'h1;
	localparam logic [2:0] CAUSE_UV = 3'h2;
	localparam logic [2:0] CAUSE_WD = 3'h4;
	// sequencer states
	typedef enum logic [3:0] {
		ST_INIT = 4'h1,
		ST_RUN = 4'h2,
		ST_HALT = 4'h4,
		ST_WAKE = 4'h8
	} seq_state_e;
endpackage

// ===== common/sysctl_if.sv
// ticks and watchdog handshake between the control core and its helpers
interface sysctl_if;
	logic sys_tick;
	logic scan_low;
	logic scan_run;
	logic [1:0] scan_rate;
	logic wd_run;
	logic wd_clear;
	logic wd_expire;
	modport ticks (output sys_tick, output scan_low, input scan_run, input scan_rate);
	modport dog (input wd_run, input wd_clear, output wd_expire);
	modport ctl (input sys_tick, input scan_low, output scan_run, output scan_rate,
		output wd_run, output wd_clear, input wd_expire);
endinterface

// ===== verilog/tick_divider.sv
// divider for the 1 MHz system tick and the key scan pulse train
module tick_divider #(
	parameter int unsigned SCAN_CYCLES = sysctl_pkg::SCAN_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	sysctl_if.ticks ifc
);
	logic [7:0] div_r;
	logic tick_r;
	logic [31:0] scan_cnt_r;
	logic scan_low_r;
	logic [31:0] scan_period;

	// system tick, one cycle in every SYS_DIV
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || div_r == 8'(sysctl_pkg::SYS_DIV - 1)) begin
			div_r <= 8'h00;
		end else begin
			div_r <= div_r + 8'h01;
		end
		tick_r <= !rst_i && div_r == 8'(sysctl_pkg::SYS_DIV - 1);
	end

	// period doubles for each step of the rate code
	assign scan_period = SCAN_CYCLES << ifc.scan_rate;

	// low pulse at the start of each scan period, only while halted
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || !ifc.scan_run || scan_cnt_r == scan_period - 32'h1) begin
			scan_cnt_r <= 32'h0;
		end else begin
			scan_cnt_r <= scan_cnt_r + 32'h1;
		end
		scan_low_r <= !rst_i && ifc.scan_run && scan_cnt_r < sysctl_pkg::SCAN_PULSE_CYCLES;
	end

	assign ifc.sys_tick = tick_r;
	assign ifc.scan_low = scan_low_r;
endmodule

// ===== verilog/watchdog_counter.sv
// watchdog counter, runs while the program executes
module watchdog_counter #(
	parameter int unsigned WDOG_CYCLES = sysctl_pkg::WDOG_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	sysctl_if.dog ifc
);
	logic [31:0] cnt_r;
	logic expire_r;

	// count run cycles, wrap and flag on timeout
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || ifc.wd_clear) begin
			cnt_r <= 32'h0;
		end else if (ifc.wd_run) begin
			cnt_r <= (cnt_r == WDOG_CYCLES - 1) ? 32'h0 : cnt_r + 32'h1;
		end
		expire_r <= !rst_i && !ifc.wd_clear && ifc.wd_run && cnt_r == WDOG_CYCLES - 1;
	end

	assign ifc.wd_expire = expire_r;

	chk_wdog_full_period: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		ifc.wd_expire |-> $past(cnt_r) == WDOG_CYCLES - 1 && cnt_r == 32'h0)
		else $error("watchdog expired before full period");
endmodule

// ===== verilog/system_reset_watchdog_io.sv
// reset sequencer, watchdog, low battery flag and 13 pull-up pins
// How it works
// - hold reset initialization 16 ms after power
// - leave initialization by loading the reset vector
// - undervoltage input forces whole-system reset; scan enables, config and irq mask/status are kept
// - read-only battery flag, 0 when low
// - watchdog runs with program, resets on timeout
// - watchdog timeout at least 0.45 s
// - only second clear right after first clears
// - thirteen pull-up pins: A, B, C, D0
// - write 1 input, write 0 drive low
// - pin direction changeable any time while running
// - key-scan pins pulse low while halted
// - wake option for port A3 and D0
// - internal 1 MHz system clock only
// - halted device wakes on enabled input low
// - wait 60 us after wake before resuming
// - undervoltage while halted gives full reset
// - scan rate selectable among four rates
module system_reset_watchdog_io #(
	parameter int unsigned INIT_CYCLES = sysctl_pkg::INIT_CYCLES,
	parameter int unsigned WDOG_CYCLES = sysctl_pkg::WDOG_CYCLES,
	parameter int unsigned WAKE_CYCLES = sysctl_pkg::WAKE_CYCLES,
	parameter int unsigned SCAN_CYCLES = sysctl_pkg::SCAN_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [3:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic we_i,
	input wire logic re_i,
	output logic [15:0] rdata_o,
	input wire logic undervoltage_i,
	input wire logic low_battery_i,
	input wire logic [12:0] pins_i,
	output logic [12:0] pin_out_o,
	output logic [12:0] pin_oe_n_o,
	output logic core_reset_o,
	output logic pc_load_o,
	output logic core_tick_o,
	output logic halted_o,
	output logic irq_o
);
	sysctl_if ifc ();

	sysctl_pkg::seq_state_e state_r;
	logic [31:0] cnt_r;
	logic [12:0] dir_r;
	logic [12:0] scan_en_r;
	logic [3:0] cfg_r;
	logic [2:0] cause_r;
	logic [1:0] irq_stat_r;
	logic [1:0] irq_mask_r;
	logic [12:0] pin_prev_r;
	logic lb_flag_prev_r;
	logic arm_r;
	logic restart_w;
	logic kick_w;
	logic halt_cmd_w;
	logic wake_w;
	logic init_done_w;
	logic [1:0] irq_set_w;
	logic [31:0] init_len_r;
	logic [31:0] wake_len_r;
	logic last_first_r;

	// pins that may wake the device, per the two wake options
	function automatic logic [12:0] wake_mask(input logic [3:0] cfg);
		logic [12:0] m;
		m = 13'h1fff;
		m[sysctl_pkg::PIN_PA3] = cfg[sysctl_pkg::CFG_WAKE_PA3];
		m[sysctl_pkg::PIN_PD0] = cfg[sysctl_pkg::CFG_WAKE_PD0];
		return m;
	endfunction

	// write decode, shared by all register processes
	function automatic logic wr_hit(input logic [3:0] a);
		return we_i && addr_i == a;
	endfunction

	// read multiplexer, unmapped offsets read zero
	function automatic logic [15:0] reg_read(input logic [3:0] a);
		logic [15:0] v;
		v = 16'h0000;
		unique case (a)
			4'h0: v[3:0] = dir_r[3:0];
			4'h1: v[3:0] = dir_r[7:4];
			4'h2: v[3:0] = dir_r[11:8];
			sysctl_pkg::ADDR_DIR_D: v[0] = dir_r[12];
			sysctl_pkg::ADDR_PINS: v[12:0] = pins_i;
			sysctl_pkg::ADDR_STATUS: begin
				v[sysctl_pkg::STAT_LOW_BAT] = !low_battery_i;
				v[sysctl_pkg::STAT_CAUSE_LSB +: 3] = cause_r;
			end
			sysctl_pkg::ADDR_SCAN_EN: v[12:0] = scan_en_r;
			sysctl_pkg::ADDR_CONFIG: v[3:0] = cfg_r;
			sysctl_pkg::ADDR_IRQ_STAT: v[1:0] = irq_stat_r;
			sysctl_pkg::ADDR_IRQ_MASK: v[1:0] = irq_mask_r;
			default: v = 16'h0000;
		endcase
		return v;
	endfunction

	// helpers on the interface
	tick_divider #(
		.SCAN_CYCLES(SCAN_CYCLES)
	) u_ticks (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.ifc(ifc.ticks)
	);

	watchdog_counter #(
		.WDOG_CYCLES(WDOG_CYCLES)
	) u_dog (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.ifc(ifc.dog)
	);

	// reset sources other than power-on
	assign restart_w = undervoltage_i || ifc.wd_expire;
	assign init_done_w = state_r == sysctl_pkg::ST_INIT && cnt_r == INIT_CYCLES - 1;
	assign halt_cmd_w = wr_hit(sysctl_pkg::ADDR_CMD) && wdata_i == sysctl_pkg::CMD_HALT;
	assign kick_w = wr_hit(sysctl_pkg::ADDR_CMD) && wdata_i == sysctl_pkg::CMD_CLEAR_SECOND
		&& arm_r;
	assign wake_w = |(pin_prev_r & ~pins_i & wake_mask(cfg_r) & pin_oe_n_o);

	// watchdog runs only while the program executes
	assign ifc.wd_run = state_r == sysctl_pkg::ST_RUN;
	assign ifc.wd_clear = kick_w || restart_w || state_r == sysctl_pkg::ST_INIT;
	assign ifc.scan_run = state_r == sysctl_pkg::ST_HALT;
	assign ifc.scan_rate = cfg_r[sysctl_pkg::CFG_RATE_LSB +: 2];

	// reset sequencer
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state_r <= sysctl_pkg::ST_INIT;
			cnt_r <= 32'h0;
		end else if (restart_w) begin
			state_r <= sysctl_pkg::ST_INIT;
			cnt_r <= 32'h0;
		end else begin
			unique case (state_r)
				sysctl_pkg::ST_INIT: begin
					if (init_done_w) begin
						state_r <= sysctl_pkg::ST_RUN;
						cnt_r <= 32'h0;
					end else begin
						cnt_r <= cnt_r + 32'h1;
					end
				end
				sysctl_pkg::ST_RUN: begin
					if (halt_cmd_w) begin
						state_r <= sysctl_pkg::ST_HALT;
					end
				end
				sysctl_pkg::ST_HALT: begin
					if (wake_w) begin
						state_r <= sysctl_pkg::ST_WAKE;
						cnt_r <= 32'h0;
					end
				end
				sysctl_pkg::ST_WAKE: begin
					if (cnt_r == WAKE_CYCLES - 1) begin
						state_r <= sysctl_pkg::ST_RUN;
						cnt_r <= 32'h0;
					end else begin
						cnt_r <= cnt_r + 32'h1;
					end
				end
			endcase
		end
	end

	// core controls: reset level, vector load, gated 1 MHz tick
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			core_reset_o <= 1'b1;
			pc_load_o <= 1'b0;
			core_tick_o <= 1'b0;
			halted_o <= 1'b0;
		end else begin
			core_reset_o <= state_r == sysctl_pkg::ST_INIT;
			pc_load_o <= init_done_w && !restart_w;
			core_tick_o <= ifc.sys_tick && state_r == sysctl_pkg::ST_RUN;
			halted_o <= state_r == sysctl_pkg::ST_HALT;
		end
	end

	// watchdog clear sequence: any bus access between the two disarms
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || restart_w) begin
			arm_r <= 1'b0;
		end else if (we_i || re_i) begin
			arm_r <= wr_hit(sysctl_pkg::ADDR_CMD) && wdata_i == sysctl_pkg::CMD_CLEAR_FIRST;
		end
	end

	// port direction bits, released to input on any reset
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || restart_w) begin
			dir_r <= sysctl_pkg::DIR_RESET;
		end else if (state_r != sysctl_pkg::ST_INIT) begin
			for (int p = 0; p < 3; p++) begin
				if (wr_hit(4'(sysctl_pkg::ADDR_DIR_A + p))) begin
					dir_r[p*4 +: 4] <= wdata_i[3:0];
				end
			end
			if (wr_hit(sysctl_pkg::ADDR_DIR_D)) begin
				dir_r[12] <= wdata_i[0];
			end
		end
	end

	// configuration: scan enables, wake options, scan rate
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			scan_en_r <= 13'h0000;
			cfg_r <= sysctl_pkg::CFG_RESET;
			irq_mask_r <= 2'h0;
		end else begin
			if (wr_hit(sysctl_pkg::ADDR_SCAN_EN)) begin
				scan_en_r <= wdata_i[12:0];
			end
			if (wr_hit(sysctl_pkg::ADDR_CONFIG)) begin
				cfg_r <= wdata_i[3:0];
			end
			if (wr_hit(sysctl_pkg::ADDR_IRQ_MASK)) begin
				irq_mask_r <= wdata_i[1:0];
			end
		end
	end

	// cause of the last reset
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			cause_r <= sysctl_pkg::CAUSE_POR;
		end else if (undervoltage_i) begin
			cause_r <= sysctl_pkg::CAUSE_UV;
		end else if (ifc.wd_expire) begin
			cause_r <= sysctl_pkg::CAUSE_WD;
		end
	end

	// pin drivers: low when direction bit is 0 or scan pulse in halt
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			pin_oe_n_o <= 13'h1fff;
			pin_out_o <= 13'h0000;
			pin_prev_r <= 13'h1fff;
		end else begin
			pin_oe_n_o <= dir_r & ~(scan_en_r & {13{ifc.scan_run && ifc.scan_low}});
			pin_out_o <= 13'h0000;
			pin_prev_r <= pins_i;
		end
	end

	// interrupt events: wake-up, battery flag falling
	assign irq_set_w[sysctl_pkg::IRQ_WAKE] = state_r == sysctl_pkg::ST_HALT && wake_w && !restart_w;
	assign irq_set_w[sysctl_pkg::IRQ_LOW_BAT] = lb_flag_prev_r && low_battery_i;

	// sticky status, write one to clear, a new event wins
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			irq_stat_r <= 2'h0;
			lb_flag_prev_r <= 1'b1;
			irq_o <= 1'b0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~({2{wr_hit(sysctl_pkg::ADDR_IRQ_STAT)}} & wdata_i[1:0]))
				| irq_set_w;
			lb_flag_prev_r <= !low_battery_i;
			irq_o <= |(irq_stat_r & irq_mask_r);
		end
	end

	// read data, valid the cycle after the strobe only
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || !re_i) begin
			rdata_o <= 16'h0000;
		end else begin
			rdata_o <= reg_read(addr_i);
		end
	end

	// checking helpers: length of each initialization and wake wait, last bus access
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || restart_w || state_r != sysctl_pkg::ST_INIT) begin
			init_len_r <= (state_r == sysctl_pkg::ST_INIT && !rst_i && !restart_w)
				? init_len_r + 32'h1 : 32'h0;
		end else begin
			init_len_r <= init_len_r + 32'h1;
		end
		if (rst_i || state_r != sysctl_pkg::ST_WAKE) begin
			wake_len_r <= 32'h0;
		end else begin
			wake_len_r <= wake_len_r + 32'h1;
		end
		// idle cycles keep the last access, so a gap between the pair is legal
		if (rst_i) begin
			last_first_r <= 1'b0;
		end else if (we_i || re_i) begin
			last_first_r <= we_i && addr_i == sysctl_pkg::ADDR_CMD
				&& wdata_i == sysctl_pkg::CMD_CLEAR_FIRST;
		end
	end

	chk_init_length: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_r == sysctl_pkg::ST_RUN && $past(state_r) == sysctl_pkg::ST_INIT
		|-> init_len_r == INIT_CYCLES)
		else $error("initialization wait has wrong length");

	chk_vector_load: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		pc_load_o |-> state_r == sysctl_pkg::ST_RUN && $past(state_r) == sysctl_pkg::ST_INIT
		##1 !pc_load_o && !core_reset_o)
		else $error("vector load not tied to leaving initialization");

	chk_uv_reset: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		undervoltage_i |=> state_r == sysctl_pkg::ST_INIT ##1 core_reset_o)
		else $error("undervoltage did not reset the system");

	chk_battery_read: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		re_i && addr_i == sysctl_pkg::ADDR_STATUS
		|=> rdata_o[sysctl_pkg::STAT_LOW_BAT] == !$past(low_battery_i))
		else $error("battery flag reads wrong value");

	chk_wdog_restart: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		ifc.wd_expire |=> state_r == sysctl_pkg::ST_INIT ##1 core_reset_o)
		else $error("watchdog timeout gave no reset");

	chk_clear_pair: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		kick_w |-> last_first_r ##1 u_dog.cnt_r == 32'h0)
		else $error("watchdog cleared without preceding first clear");

	chk_dir_effect: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		we_i && addr_i == sysctl_pkg::ADDR_DIR_A
		&& state_r == sysctl_pkg::ST_RUN && !restart_w
		##1 state_r == sysctl_pkg::ST_RUN && !restart_w
		|=> pin_oe_n_o[3:0] == $past(wdata_i[3:0], 2))
		else $error("port A direction write not seen on pins");

	chk_scan_pulse: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_r == sysctl_pkg::ST_HALT && ifc.scan_low |=> (pin_oe_n_o & $past(scan_en_r)) == 13'h0)
		else $error("scan pin not driven during halt pulse");

	chk_halt_wake: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_r == sysctl_pkg::ST_HALT && !restart_w
		&& |(pin_prev_r & ~pins_i & wake_mask(cfg_r) & pin_oe_n_o)
		|=> state_r == sysctl_pkg::ST_WAKE && !core_tick_o)
		else $error("enabled pin low did not wake");

	chk_wake_wait: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_r == sysctl_pkg::ST_RUN && $past(state_r) == sysctl_pkg::ST_WAKE
		|-> $past(wake_len_r) == WAKE_CYCLES - 1)
		else $error("wake wait has wrong length");

	chk_reset_pins: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		restart_w |=> ##1 pin_oe_n_o == 13'h1fff)
		else $error("pins not released after reset");

	cov_boot: cover property (@(posedge ref_clk_i) disable iff (rst_i) pc_load_o);
	cov_wake: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		state_r == sysctl_pkg::ST_WAKE ##1 state_r == sysctl_pkg::ST_RUN);
	cov_kick: cover property (@(posedge ref_clk_i) disable iff (rst_i) kick_w);
	cov_expire: cover property (@(posedge ref_clk_i) disable iff (rst_i) ifc.wd_expire);
endmodule

// ===== verification/keypad_model.sv
// keypad switch model: each closed key grounds its pin
module keypad_model (
	input wire logic [12:0] pin_out_i,
	input wire logic [12:0] pin_oe_n_i,
	input wire logic [12:0] key_down_i,
	output logic [12:0] pins_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// a driven pin shows its output, a released one its pull-up; a closed key wins
	always_comb begin
		pins_o = (pin_out_i | pin_oe_n_i) & ~key_down_i;
	end
endmodule

// ===== verification/system_reset_watchdog_io_tb_top.sv
// self-checking bench of the reset sequencer, watchdog and pull-up pins
module system_reset_watchdog_io_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int P_INIT = 200;
	localparam int P_WDOG = 500;
	localparam int P_WAKE = 20;
	localparam int P_SCAN = 300;
	logic ref_clk_i, rst_i, we_i, re_i, undervoltage_i, low_battery_i;
	logic core_reset_o, pc_load_o, core_tick_o, halted_o, irq_o, scan0;
	logic [3:0] addr_i;
	logic [15:0] wdata_i, rdata_o;
	logic [12:0] pins_i, pin_out_o, pin_oe_n_o, key_down;
	int err_total = 0;
	int checks_done = 0;
	int cycles = 0;
	assign scan0 = pin_oe_n_o[0];
	// block under test and the keypad on its pins
	system_reset_watchdog_io #(.INIT_CYCLES(P_INIT), .WDOG_CYCLES(P_WDOG),
		.WAKE_CYCLES(P_WAKE), .SCAN_CYCLES(P_SCAN)) u_system_reset_watchdog_io (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .undervoltage_i(undervoltage_i),
		.low_battery_i(low_battery_i), .pins_i(pins_i), .pin_out_o(pin_out_o),
		.pin_oe_n_o(pin_oe_n_o), .core_reset_o(core_reset_o), .pc_load_o(pc_load_o),
		.core_tick_o(core_tick_o), .halted_o(halted_o), .irq_o(irq_o));
	keypad_model u_keypad_model (.pin_out_i(pin_out_o), .pin_oe_n_i(pin_oe_n_o),
		.key_down_i(key_down), .pins_o(pins_i));
	// clock
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	// hang guard
	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			err_total++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// a count outside its window is reported against the nearest bound
	task automatic near(input string what, input int n, input int lo, input int hi);
		chk(what, 16'(n), 16'(n < lo ? lo : (n > hi ? hi : n)));
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk_i);
		we_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge ref_clk_i);
		we_i <= 1'b0;
	endtask
	task automatic rchk(input string what, input logic [3:0] a, input logic [15:0] exp);
		@(posedge ref_clk_i);
		re_i <= 1'b1;
		addr_i <= a;
		@(posedge ref_clk_i);
		re_i <= 1'b0;
		#1;
		chk(what, rdata_o, exp);
	endtask
	task automatic wait_lvl(ref logic s, input logic lvl, output int n);
		n = 0;
		while (s !== lvl && n < 5000) begin
			@(posedge ref_clk_i);
			#1;
			n++;
		end
	endtask
	task automatic settle(input int k);
		repeat (k) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic t_power_on();
		int n;
		#1;
		chk("oe_n in init", 16'(pin_oe_n_o), 16'h1fff);
		wait_lvl(pc_load_o, 1'b1, n);
		near("init wait", n, P_INIT, P_INIT + 3);
		settle(1);
		chk("load pulse ends", 16'(pc_load_o), 16'h0000);
		chk("core out of reset", 16'(core_reset_o), 16'h0000);
		wait_lvl(core_tick_o, 1'b1, n);
		settle(1);
		wait_lvl(core_tick_o, 1'b1, n);
		chk("tick period", 16'(n), 16'(sysctl_pkg::SYS_DIV - 1));
		rchk("status after power", sysctl_pkg::ADDR_STATUS, 16'h0003);
	endtask
	task automatic t_pins();
		wr(sysctl_pkg::ADDR_DIR_A, 16'h000e);
		wr(sysctl_pkg::ADDR_DIR_D, 16'h0000);
		settle(1);
		chk("oe_n after dir", 16'(pin_oe_n_o), 16'h0ffe);
		chk("pin out low", 16'(pin_out_o), 16'h0000);
		key_down <= 13'h0010;
		rchk("pin levels", sysctl_pkg::ADDR_PINS, 16'h0fee);
		settle(1);
		chk("read data one cycle", rdata_o, 16'h0000);
		rchk("unmapped read", 4'hb, 16'h0000);
		key_down <= 13'h0000;
		wr(sysctl_pkg::ADDR_DIR_A, 16'h000f);
		wr(sysctl_pkg::ADDR_DIR_D, 16'h0001);
		settle(1);
		chk("oe_n released", 16'(pin_oe_n_o), 16'h1fff);
	endtask
	task automatic t_low_battery();
		low_battery_i <= 1'b1;
		settle(4);
		chk("irq masked", 16'(irq_o), 16'h0000);
		wr(sysctl_pkg::ADDR_IRQ_MASK, 16'h0002);
		settle(2);
		chk("irq raised", 16'(irq_o), 16'h0001);
		wr(sysctl_pkg::ADDR_STATUS, 16'h0001);
		rchk("flag low", sysctl_pkg::ADDR_STATUS, 16'h0002);
		wr(sysctl_pkg::ADDR_IRQ_STAT, 16'h0002);
		settle(2);
		chk("irq cleared", 16'(irq_o), 16'h0000);
		low_battery_i <= 1'b0;
		rchk("flag high", sysctl_pkg::ADDR_STATUS, 16'h0003);
	endtask
	task automatic t_watchdog();
		int n;
		int t0;
		wr(sysctl_pkg::ADDR_DIR_A, 16'h0000);
		wr(sysctl_pkg::ADDR_CMD, sysctl_pkg::CMD_CLEAR_FIRST);
		wr(sysctl_pkg::ADDR_CMD, sysctl_pkg::CMD_CLEAR_SECOND);
		repeat (3) begin
			settle(400);
			wr(sysctl_pkg::ADDR_CMD, sysctl_pkg::CMD_CLEAR_FIRST);
			wr(sysctl_pkg::ADDR_CMD, sysctl_pkg::CMD_CLEAR_SECOND);
		end
		t0 = cycles;
		settle(1);
		chk("pair keeps dog off", 16'(pin_oe_n_o[3:0]), 16'h0000);
		settle(300);
		wr(sysctl_pkg::ADDR_CMD, sysctl_pkg::CMD_CLEAR_FIRST);
		rchk("between clears", sysctl_pkg::ADDR_DIR_A, 16'h0000);
		wr(sysctl_pkg::ADDR_CMD, sysctl_pkg::CMD_CLEAR_SECOND);
		wr(sysctl_pkg::ADDR_CMD, sysctl_pkg::CMD_CLEAR_SECOND);
		wait_lvl(core_reset_o, 1'b1, n);
		near("bite time", cycles - t0, P_WDOG, P_WDOG + 5);
		chk("dir after bite", 16'(pin_oe_n_o), 16'h1fff);
		wait_lvl(pc_load_o, 1'b1, n);
		near("init after bite", n, P_INIT - 2, P_INIT + 3);
		rchk("cause watchdog", sysctl_pkg::ADDR_STATUS, 16'h0009);
	endtask
	task automatic t_scan_wake();
		int n;
		int w;
		wr(sysctl_pkg::ADDR_SCAN_EN, 16'h0001);
		for (int r = 0; r < 4; r++) begin
			wr(sysctl_pkg::ADDR_CONFIG, 16'(r << 2) | 16'h0001);
			wr(sysctl_pkg::ADDR_CMD, sysctl_pkg::CMD_HALT);
			wait_lvl(scan0, 1'b0, n);
			wait_lvl(scan0, 1'b1, w);
			chk("scan width", 16'(w), 16'(sysctl_pkg::SCAN_PULSE_CYCLES));
			wait_lvl(scan0, 1'b0, n);
			chk("scan period", 16'(n + w), 16'(P_SCAN << r));
			@(posedge ref_clk_i);
			key_down <= 13'h1000;
			settle(30);
			chk("pd0 wake off", 16'(halted_o), 16'h0001);
			key_down <= 13'h1008;
			wait_lvl(core_tick_o, 1'b1, n);
			near("wake wait", n, P_WAKE, P_WAKE + sysctl_pkg::SYS_DIV + 4);
			@(posedge ref_clk_i);
			key_down <= 13'h0000;
		end
		// other wake option: port D pin 0 only, port A pin 3 must not wake
		wr(sysctl_pkg::ADDR_CMD, sysctl_pkg::CMD_CLEAR_FIRST);
		wr(sysctl_pkg::ADDR_CMD, sysctl_pkg::CMD_CLEAR_SECOND);
		wr(sysctl_pkg::ADDR_CONFIG, 16'h0002);
		wr(sysctl_pkg::ADDR_CMD, sysctl_pkg::CMD_HALT);
		key_down <= 13'h0008;
		settle(30);
		chk("pa3 wake off", 16'(halted_o), 16'h0001);
		key_down <= 13'h1008;
		wait_lvl(core_tick_o, 1'b1, n);
		near("pd0 wake", n, P_WAKE, P_WAKE + sysctl_pkg::SYS_DIV + 4);
		@(posedge ref_clk_i);
		key_down <= 13'h0000;
		rchk("wake event", sysctl_pkg::ADDR_IRQ_STAT, 16'h0001);
	endtask
	task automatic t_undervoltage();
		int n;
		wr(sysctl_pkg::ADDR_CMD, sysctl_pkg::CMD_HALT);
		undervoltage_i <= 1'b1;
		settle(P_INIT + 50);
		chk("held in reset", 16'(core_reset_o), 16'h0001);
		chk("not resumed", 16'(halted_o), 16'h0000);
		undervoltage_i <= 1'b0;
		wait_lvl(pc_load_o, 1'b1, n);
		near("init after undervoltage", n, P_INIT, P_INIT + 3);
		rchk("cause undervoltage", sysctl_pkg::ADDR_STATUS, 16'h0005);
	endtask
	// main sequence
	initial begin
		rst_i = 1'b1;
		addr_i = 4'h0;
		wdata_i = 16'h0000;
		we_i = 1'b0;
		re_i = 1'b0;
		undervoltage_i = 1'b0;
		low_battery_i = 1'b0;
		key_down = 13'h0000;
		repeat (6) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		t_power_on();
		t_pins();
		t_low_battery();
		t_watchdog();
		t_scan_wake();
		t_undervoltage();
		summarize();
	end
endmodule
